// *** caid_regs.vh ***
`ifndef CAID_REGS_VH
`define CAID_REGS_VH

`define CAID_OPC_HI        15
`define CAID_OPC_LO        10
`define CAID_OPC_GROUP_E   6'h1B
`define CAID_RD_HI         9
`define CAID_RD_LO         7
`define CAID_RS_HI         6
`define CAID_RS_LO         4
`define CAID_IMM3_HI       3
`define CAID_IMM3_LO       1
`define CAID_IMM9_HI       9
`define CAID_IMM9_LO       1
`define CAID_FORM_BIT      0
`define CAID_FORM_TWO_REG  1'h0
`define CAID_FORM_SP       1'h1
`define CAID_SP_REG        5'h1D
`define CAID_ZERO_REG      5'h00
`define CAID_ZERO_WORD     32'h0000_0000
`define CAID_SEL_HI_BASE   5'h10
`define CAID_SEL_LOW_MAX   3'h1
`define CAID_IMM9_CODE0    9'h000
`define CAID_IMM9_CODE1    9'h001
`define CAID_IMM9_CODE510  9'h1FE
`define CAID_IMM9_CODE511  9'h1FF
`define CAID_IMM9_VAL0     9'h100
`define CAID_IMM9_VAL1     9'h101
`define CAID_IMM9_VAL510   10'h2FE
`define CAID_IMM9_VAL511   10'h2FF

`endif

// *** caid_reg_xlat.v ***
`timescale 1ns/1ps
// Maps a 3-bit compact selector to a full 5-bit general register number.
module caid_reg_xlat (
  input  wire [2:0] sel,
  output wire [4:0] reg_num
);
`include "caid_regs.vh"

  assign reg_num = (sel <= `CAID_SEL_LOW_MAX) ?
                   (`CAID_SEL_HI_BASE | {4'h0, sel[0]}) :
                   {2'h0, sel};

endmodule // caid_reg_xlat

// *** caid_core.v ***
`timescale 1ns/1ps
// Summary of operation
// - The two-register form is opcode 011011 in bits 15:10 with dest 9:7, source 6:4, immediate code 3:1 and bit 0 clear.
// - The two-register form writes source value plus the sign-extended decoded immediate to the destination.
// - Immediate codes 0 to 6 give 1,4,8,12,16,20,24 and code 7 gives minus one.
// - Each 3-bit selector addresses only registers 2 to 7, 16 and 17.
// - Neither form raises an overflow or any other exception.
// - Both sums are 32-bit modulo, the carry out of bit 31 is dropped.
// - The stack form adds the decoded immediate times four, sign-extended, to register 29 and writes register 29.
// - Stack codes 2-255 keep value, 256-509 become code minus 512, and 0,1,510,511 give 256,257,-258,-257.
//
// Cycle 0: instr and instr_valid present; read selectors are driven
// combinationally from instr. The core reads the operand on src_data in
// the same cycle. Cycle 1: result, write select and write enable are
// registered outputs valid for one cycle.
module caid_core (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        instr_valid,
  input  wire [15:0] instr,
  input  wire [31:0] src_data,
  output wire [4:0]  src_reg_sel,
  output reg         wr_en_q,
  output reg  [4:0]  wr_sel_q,
  output reg  [31:0] wr_data_q,
  output reg         exc_q,
  output reg         is_two_reg_q,
  output reg         is_stack_q
);
`include "caid_regs.vh"

  wire        group_e;
  wire        add_imm_two_reg;
  wire        add_imm_stack_ptr;
  wire [4:0]  dst_sel;
  wire [4:0]  xlat_src;
  wire [2:0]  imm3;
  wire [8:0]  imm9;
  reg  [31:0] imm2_ext;
  reg  [9:0]  imm9_dec;
  wire [31:0] imm_sp_ext;
  wire [31:0] addend;
  wire [31:0] sum;
  wire        any_hit;

  assign group_e = instr[`CAID_OPC_HI:`CAID_OPC_LO] == `CAID_OPC_GROUP_E;
  // The low bit splits the group: clear selects the two-register form.
  assign add_imm_two_reg   = group_e &&
    (instr[`CAID_FORM_BIT] == `CAID_FORM_TWO_REG);
  assign add_imm_stack_ptr = group_e &&
    (instr[`CAID_FORM_BIT] == `CAID_FORM_SP);
  assign imm3 = instr[`CAID_IMM3_HI:`CAID_IMM3_LO];
  assign imm9 = instr[`CAID_IMM9_HI:`CAID_IMM9_LO];

  caid_reg_xlat u_dst (
    .sel     (instr[`CAID_RD_HI:`CAID_RD_LO]),
    .reg_num (dst_sel)
  );

  caid_reg_xlat u_src (
    .sel     (instr[`CAID_RS_HI:`CAID_RS_LO]),
    .reg_num (xlat_src)
  );

  // The stack form reads register 29, otherwise the translated source.
  assign src_reg_sel = add_imm_stack_ptr ? `CAID_SP_REG : xlat_src;

  always @* begin
    case (imm3)
      3'h0:    imm2_ext = 32'h0000_0001;
      3'h1:    imm2_ext = 32'h0000_0004;
      3'h2:    imm2_ext = 32'h0000_0008;
      3'h3:    imm2_ext = 32'h0000_000C;
      3'h4:    imm2_ext = 32'h0000_0010;
      3'h5:    imm2_ext = 32'h0000_0014;
      3'h6:    imm2_ext = 32'h0000_0018;
      default: imm2_ext = 32'hFFFF_FFFF;
    endcase
  end

  // Decoded stack immediate is held as a 10-bit two's complement value.
  always @* begin
    case (imm9)
      `CAID_IMM9_CODE0:   imm9_dec = {1'b0, `CAID_IMM9_VAL0};
      `CAID_IMM9_CODE1:   imm9_dec = {1'b0, `CAID_IMM9_VAL1};
      `CAID_IMM9_CODE510: imm9_dec = `CAID_IMM9_VAL510;
      `CAID_IMM9_CODE511: imm9_dec = `CAID_IMM9_VAL511;
      default:            imm9_dec = {imm9[8], imm9};
    endcase
  end

  assign imm_sp_ext = {{20{imm9_dec[9]}}, imm9_dec, 2'b00};
  assign addend = add_imm_stack_ptr ? imm_sp_ext : imm2_ext;
  // Carry out of bit 31 is dropped; no overflow flag exists to trap on.
  assign sum = src_data + addend;
  assign any_hit = instr_valid && group_e;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_en_q      <= 1'b0;
      wr_sel_q     <= `CAID_ZERO_REG;
      wr_data_q    <= `CAID_ZERO_WORD;
      exc_q        <= 1'b0;
      is_two_reg_q <= 1'b0;
      is_stack_q   <= 1'b0;
    end else begin
      wr_en_q      <= any_hit;
      wr_sel_q     <= add_imm_stack_ptr ? `CAID_SP_REG : dst_sel;
      wr_data_q    <= sum;
      // These forms never signal an exception.
      exc_q        <= 1'b0;
      is_two_reg_q <= instr_valid && add_imm_two_reg;
      is_stack_q   <= instr_valid && add_imm_stack_ptr;
    end
  end

endmodule // caid_core

// *** caid_chk_sva.sv ***
`timescale 1ns/1ps
module caid_chk (
  input logic        clk, sys_rst, instr_valid, wr_en_q, exc_q,
  input logic        is_two_reg_q, is_stack_q,
  input logic [15:0] instr,
  input logic [31:0] src_data, wr_data_q,
  input logic [4:0]  src_reg_sel, wr_sel_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire tk = instr_valid && instr[15:10] == 6'h1B;
  wire [8:0] c = instr[9:1];
  wire [31:0] i3 = &instr[3:1] ? '1 : instr[3:1] * 4 + (instr[3:1] == 0);
  wire [31:0] i9 = (c < 2 ? c + 256 : c > 509 ? c - 768 :
                    c > 255 ? c - 512 : c) * 4;
  logic [31:0] s2_q, s9_q;
  logic [2:0]  d_q;
  function automatic logic [4:0] x(logic [2:0] s);
    return s < 2 ? s + 5'h10 : s;
  endfunction
  always_ff @(posedge clk) begin
    s2_q <= src_data + i3;
    s9_q <= src_data + i9;
    d_q <= instr[9:7];
  end
  take_a: assert property (tk |=> wr_en_q) else $error("no write");
  refuse_a: assert property (!tk |=> !wr_en_q) else $error("write");
  no_exc_a: assert property (!exc_q) else $error("exception");
  sp_src_a:
    assert property (tk && instr[0] |-> src_reg_sel == 5'h1D) else $error("sp");
  src_map_a:
    assert property (tk && !instr[0] |-> src_reg_sel == x(instr[6:4]))
      else $error("src sel");
  dst_map_a:
    assert property (tk && !instr[0] |=> wr_sel_q == x(d_q) && is_two_reg_q)
      else $error("dst sel");
  two_sum_a:
    assert property (tk && !instr[0] |=> wr_data_q == s2_q) else $error("sum");
  sp_sum_a:
    assert property (tk && instr[0] |=> wr_data_q == s9_q && is_stack_q)
      else $error("sp sum");
  cover property (tk && instr[0]);
  cover property (tk && &instr[3:1] && !instr[0]);
  cover property (tk ##1 !tk);
endmodule // caid_chk
bind caid_core caid_chk i_caid_chk (.clk, .sys_rst, .instr_valid, .instr,
  .src_data, .src_reg_sel, .wr_en_q, .wr_sel_q, .wr_data_q, .exc_q,
  .is_two_reg_q, .is_stack_q);

// *** compact_add_immediate_decode_bench.sv ***
`timescale 1ns/1ps
module compact_add_immediate_decode_bench;
  logic        clk = 0, sys_rst = 1, instr_valid = 0;
  logic [15:0] instr = 16'h0000;
  logic [31:0] src_data = 32'h0000_0000;
  wire  [4:0]  src_reg_sel, wr_sel_q;
  wire  [31:0] wr_data_q;
  wire         wr_en_q, exc_q, is_two_reg_q, is_stack_q;
  logic [4:0]  sel;
  int          errors = 0, checks = 0;
  caid_core i_caid_core (.clk, .sys_rst, .instr_valid, .instr, .src_data,
    .src_reg_sel, .wr_en_q, .wr_sel_q, .wr_data_q, .exc_q, .is_two_reg_q,
    .is_stack_q);
  initial forever #20 clk = ~clk;
  task final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cmp(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // The gap cycle after each issue lets the write pulse fall before reuse.
  task issue(input logic [15:0] ins, input logic v, input logic [31:0] s);
    @(posedge clk) {instr, instr_valid, src_data} <= {ins, v, s};
    #1 sel = src_reg_sel;
    @(posedge clk) instr_valid <= 1'b0;
    #1 cmp(wr_en_q, v && ins[15:10] == 6'h1B);
  endtask
  task t_imm3;
    int d[8] = '{1, 4, 8, 12, 16, 20, 24, -1};
    for (int c = 0; c < 8; c++) begin
      issue({6'h1B, 3'h2, 3'h3, c[2:0], 1'b0}, 1'b1, 32'hFFFF_FFF0);
      cmp(wr_data_q, 32'hFFFF_FFF0 + d[c]);
      cmp(exc_q, 32'h0000_0000);
    end
    $display("imm3 done");
  endtask
  task t_regs;
    for (int c = 0; c < 8; c++) begin
      issue({6'h1B, c[2:0], c[2:0], 4'h0}, 1'b1, 32'h0000_0005);
      cmp(sel, c < 2 ? c + 16 : c);
      cmp(wr_sel_q, c < 2 ? c + 16 : c);
      cmp(is_two_reg_q, 32'h0000_0001);
    end
    $display("regs done");
  endtask
  task t_sp;
    int k[8] = '{0, 1, 2, 255, 256, 509, 510, 511};
    int d[8] = '{256, 257, 2, 255, -256, -3, -258, -257};
    for (int i = 0; i < 8; i++) begin
      issue({6'h1B, k[i][8:0], 1'b1}, 1'b1, 32'h0000_0400);
      cmp(sel, 32'h0000_001D);
      cmp(wr_data_q, 32'h0000_0400 + d[i] * 4);
      cmp(wr_sel_q, 32'h0000_001D);
      cmp(is_stack_q, 32'h0000_0001);
    end
    $display("stack done");
  endtask
  task t_misc;
    issue(16'h6C00, 1'b0, 32'h0000_0000);
    issue(16'h6800, 1'b1, 32'h0000_0000);
    cmp(exc_q, 32'h0000_0000);
    $display("refuse done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_imm3;
    t_regs;
    t_sp;
    t_misc;
    final_report;
  end
  initial begin
    #20000;
    errors++;
    final_report;
  end
endmodule // compact_add_immediate_decode_bench
